/* design/reset_cause_defines.svh */
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_STATUS 8'h03
`define OFS_PWRFLAG 8'h0E
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h11
`define OFS_HOLD_BASE 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_TIMEOUT 4
`define BIT_POWERDOWN 3
`define BIT_PWRFLAG_POR 1
`define BIT_PWRFLAG_BROWNOUT 0
`define IRQ_POR 0
`define IRQ_BROWNOUT 1
`define IRQ_PIN 2
`define IRQ_WATCHDOG_RST 3
`define IRQ_WATCHDOG_WAKE 4
`define IRQ_IRQ_WAKE 5

// ----------------------------------------------------------------
// reset values and interrupt vector
// ----------------------------------------------------------------
`define STATUS_RST 8'h18
`define PWRFLAG_AFTER_POR 2'h0
`define PWRFLAG_AFTER_BROWNOUT 2'h2
`define IRQ_STAT_RST 6'h01
`define IRQ_MASK_RST 6'h00
`define IRQ_VECTOR 16'h0004

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define PIN_MIN_NS 2000
`define PIN_MIN_CYC ((`PIN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* design/reset_cause_pkg.sv */
package reset_cause_pkg;

  // register bus request carried as one bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } regReq_t;

  // reset or wake-up cause seen in one cycle
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_BROWNOUT,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WATCHDOG_RUN,
    CAUSE_WATCHDOG_WAKE,
    CAUSE_IRQ_WAKE
  } cause_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STATUS,
    SEL_PWRFLAG,
    SEL_IRQ_STAT,
    SEL_IRQ_MASK,
    SEL_HOLD
  } sel_t;

endpackage : reset_cause_pkg

/* design/reset_cause_and_wakeup_state.sv */
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "reset_cause_defines.svh"

module reset_cause_and_wakeup_state #(
  parameter int PC_W = 13,
  parameter int HOLD_N = 4,
  parameter int PIN_FILT_CYC = `PIN_MIN_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic masterClearPin_n,
  input wire logic brownoutEvent,
  input wire logic watchdogExpire,
  input wire logic irqPending,
  input wire logic globalIrqEnable,
  input wire logic sleepEnter,
  input wire logic instrDone,
  input wire logic [PC_W-1:0] pcIn,
  input wire reset_cause_pkg::regReq_t regReq,
  output logic [7:0] regRdData,
  output logic pcLoad,
  output logic [PC_W-1:0] pcTarget,
  output logic coreReset,
  output logic asleep,
  output logic irq
);
  import reset_cause_pkg::*;

  localparam int CNT_W = $clog2(PIN_FILT_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] statusByte_ff;
  logic [1:0] powerControlReg_ff;
  logic [5:0] irqStat_ff;
  logic [5:0] irqMask_ff;
  logic [7:0] holdMem [HOLD_N];
  logic [CNT_W-1:0] lowCnt_ff;
  logic asleep_ff;
  logic vectorPend_ff;
  logic pcLoad_ff;
  logic [PC_W-1:0] pcTarget_ff;
  logic coreReset_ff;
  logic irq_ff;
  logic [7:0] regRdData_ff;
  logic pinResetEvent;
  cause_t nxt_cause;
  sel_t wrSel;
  sel_t rdSel;
  logic [5:0] nxt_irqStat;
  logic [5:0] irqSet;
  logic [5:0] irqClr;
  logic isReset;

  // map an address onto a register
  function automatic sel_t regSel(input logic [7:0] a);
    if (a == `OFS_STATUS) regSel = SEL_STATUS;
    else if (a == `OFS_PWRFLAG) regSel = SEL_PWRFLAG;
    else if (a == `OFS_IRQ_STAT) regSel = SEL_IRQ_STAT;
    else if (a == `OFS_IRQ_MASK) regSel = SEL_IRQ_MASK;
    else if (a >= `OFS_HOLD_BASE && a < `OFS_HOLD_BASE + 8'(HOLD_N))
      regSel = SEL_HOLD;
    else regSel = SEL_NONE;
  endfunction : regSel

  assign wrSel = regSel(regReq.addr);
  assign rdSel = regSel(regReq.addr);

  // ----------------------------------------------------------------
  // master-clear noise filter
  // ----------------------------------------------------------------
  // count consecutive low samples; fire once on reaching the minimum
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lowCnt_ff <= '0;
    end else if (clkEn) begin
      if (masterClearPin_n) begin
        lowCnt_ff <= '0;
      end else if (lowCnt_ff != CNT_W'(PIN_FILT_CYC)) begin
        lowCnt_ff <= CNT_W'(lowCnt_ff + 1'b1);
      end
    end
  end

  assign pinResetEvent = !masterClearPin_n && (lowCnt_ff == CNT_W'(PIN_FILT_CYC - 1));

  // ----------------------------------------------------------------
  // cause decode
  // ----------------------------------------------------------------
  // brown-out wins, then pin, then watchdog, then interrupt wake
  always_comb begin
    nxt_cause = CAUSE_NONE;
    if (brownoutEvent) nxt_cause = CAUSE_BROWNOUT;
    else if (pinResetEvent && asleep_ff) nxt_cause = CAUSE_PIN_SLEEP;
    else if (pinResetEvent) nxt_cause = CAUSE_PIN_RUN;
    else if (watchdogExpire && asleep_ff) nxt_cause = CAUSE_WATCHDOG_WAKE;
    else if (watchdogExpire) nxt_cause = CAUSE_WATCHDOG_RUN;
    else if (irqPending && asleep_ff) nxt_cause = CAUSE_IRQ_WAKE;
  end

  assign isReset = nxt_cause inside {CAUSE_BROWNOUT, CAUSE_PIN_RUN,
                                     CAUSE_PIN_SLEEP, CAUSE_WATCHDOG_RUN};

  // ----------------------------------------------------------------
  // status byte
  // ----------------------------------------------------------------
  // flags follow the cause; software writes all but timeout/power-down
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      statusByte_ff <= `STATUS_RST;
    end else if (clkEn) begin
      unique case (nxt_cause)
        CAUSE_BROWNOUT: statusByte_ff <= `STATUS_RST;
        CAUSE_PIN_RUN: statusByte_ff[7:5] <= 3'h0;
        CAUSE_PIN_SLEEP: begin
          statusByte_ff[7:5] <= 3'h0;
          statusByte_ff[`BIT_TIMEOUT] <= 1'b1;
          statusByte_ff[`BIT_POWERDOWN] <= 1'b0;
        end
        CAUSE_WATCHDOG_RUN: begin
          statusByte_ff[7:5] <= 3'h0;
          statusByte_ff[`BIT_TIMEOUT] <= 1'b0;
        end
        CAUSE_WATCHDOG_WAKE: begin
          statusByte_ff[`BIT_TIMEOUT] <= 1'b0;
          statusByte_ff[`BIT_POWERDOWN] <= 1'b0;
        end
        CAUSE_IRQ_WAKE: begin
          statusByte_ff[`BIT_TIMEOUT] <= 1'b1;
          statusByte_ff[`BIT_POWERDOWN] <= 1'b0;
        end
        CAUSE_NONE: begin
          if (sleepEnter) begin
            statusByte_ff[`BIT_TIMEOUT] <= 1'b1;
            statusByte_ff[`BIT_POWERDOWN] <= 1'b0;
          end else if (regReq.wr && wrSel == SEL_STATUS) begin
            statusByte_ff[7:5] <= regReq.wrData[7:5];
            statusByte_ff[2:0] <= regReq.wrData[2:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power control flags
  // ----------------------------------------------------------------
  // hardware clears on its own event, software sets by writing ones
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      powerControlReg_ff <= `PWRFLAG_AFTER_POR;
    end else if (clkEn) begin
      if (nxt_cause == CAUSE_BROWNOUT) begin
        powerControlReg_ff <= `PWRFLAG_AFTER_BROWNOUT;
      end else if (nxt_cause == CAUSE_NONE && regReq.wr && wrSel == SEL_PWRFLAG) begin
        // a write beside a pin, watchdog or wake cause is dropped so the flags stay unchanged
        powerControlReg_ff <= powerControlReg_ff | regReq.wrData[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep tracking
  // ----------------------------------------------------------------
  // any reset or wake ends sleep
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      asleep_ff <= 1'b0;
    end else if (clkEn) begin
      if (nxt_cause != CAUSE_NONE) asleep_ff <= 1'b0;
      else if (sleepEnter) asleep_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // program counter load
  // ----------------------------------------------------------------
  // resets load zero, wakes load pc+1, a pending vector follows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pcLoad_ff <= 1'b1;
      pcTarget_ff <= '0;
      vectorPend_ff <= 1'b0;
    end else if (clkEn) begin
      pcLoad_ff <= 1'b0;
      if (isReset) begin
        pcLoad_ff <= 1'b1;
        pcTarget_ff <= '0;
        vectorPend_ff <= 1'b0;
      end else if (nxt_cause == CAUSE_WATCHDOG_WAKE || nxt_cause == CAUSE_IRQ_WAKE) begin
        pcLoad_ff <= 1'b1;
        pcTarget_ff <= PC_W'(pcIn + 1'b1);
        vectorPend_ff <= (nxt_cause == CAUSE_IRQ_WAKE) && globalIrqEnable;
      end else if (vectorPend_ff && instrDone) begin
        pcLoad_ff <= 1'b1;
        pcTarget_ff <= PC_W'(`IRQ_VECTOR);
        vectorPend_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // core register reset request
  // ----------------------------------------------------------------
  // one pulse on every true reset, none on a wake-up
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coreReset_ff <= 1'b1;
    end else if (clkEn) begin
      coreReset_ff <= isReset;
    end
  end

  // ----------------------------------------------------------------
  // hold registers
  // ----------------------------------------------------------------
  // no reset branch: contents survive every reset
  always_ff @(posedge clk) begin
    if (clkEn && regReq.wr && wrSel == SEL_HOLD) begin
      holdMem[regReq.addr[$clog2(HOLD_N)-1:0]] <= regReq.wrData;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    irqSet = '0;
    irqSet[`IRQ_BROWNOUT] = nxt_cause == CAUSE_BROWNOUT;
    irqSet[`IRQ_PIN] = nxt_cause inside {CAUSE_PIN_RUN, CAUSE_PIN_SLEEP};
    irqSet[`IRQ_WATCHDOG_RST] = nxt_cause == CAUSE_WATCHDOG_RUN;
    irqSet[`IRQ_WATCHDOG_WAKE] = nxt_cause == CAUSE_WATCHDOG_WAKE;
    irqSet[`IRQ_IRQ_WAKE] = nxt_cause == CAUSE_IRQ_WAKE;
  end

  assign irqClr = (regReq.wr && wrSel == SEL_IRQ_STAT) ? regReq.wrData[5:0] : 6'h00;
  // set wins over a write-one clear in the same cycle
  assign nxt_irqStat = (irqStat_ff & ~irqClr) | irqSet;

  // sticky event bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqStat_ff <= `IRQ_STAT_RST;
    end else if (clkEn) begin
      irqStat_ff <= nxt_irqStat;
    end
  end

  // mask takes its reset value on every true reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqMask_ff <= `IRQ_MASK_RST;
    end else if (clkEn) begin
      if (isReset) irqMask_ff <= `IRQ_MASK_RST;
      else if (regReq.wr && wrSel == SEL_IRQ_MASK) irqMask_ff <= regReq.wrData[5:0];
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else if (clkEn) begin
      irq_ff <= |(nxt_irqStat & (isReset ? `IRQ_MASK_RST : irqMask_ff));
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdData_ff <= 8'h00;
    end else if (clkEn) begin
      regRdData_ff <= 8'h00;
      if (regReq.rd) begin
        unique case (rdSel)
          SEL_STATUS: regRdData_ff <= statusByte_ff;
          SEL_PWRFLAG: regRdData_ff <= {6'h00, powerControlReg_ff};
          SEL_IRQ_STAT: regRdData_ff <= {2'h0, irqStat_ff};
          SEL_IRQ_MASK: regRdData_ff <= {2'h0, irqMask_ff};
          SEL_HOLD: regRdData_ff <= holdMem[regReq.addr[$clog2(HOLD_N)-1:0]];
          SEL_NONE: regRdData_ff <= 8'h00;
        endcase
      end
    end
  end

  assign regRdData = regRdData_ff;
  assign pcLoad = pcLoad_ff;
  assign pcTarget = pcTarget_ff;
  assign coreReset = coreReset_ff;
  assign asleep = asleep_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_pin_filter_len: assert property (
    pinResetEvent |-> !masterClearPin_n && lowCnt_ff == CNT_W'(PIN_FILT_CYC - 1))
    else $error("pin reset fired before the filter length");

  a_pin_one_shot: assert property (
    clkEn && pinResetEvent |=> !pinResetEvent)
    else $error("pin reset fired twice for one low pulse");

  a_brownout_values: assert property (
    clkEn && nxt_cause == CAUSE_BROWNOUT |=> statusByte_ff == `STATUS_RST
      && powerControlReg_ff == `PWRFLAG_AFTER_BROWNOUT && pcLoad_ff && pcTarget_ff == '0)
    else $error("brown-out values wrong");

  a_pin_run_state: assert property (
    clkEn && nxt_cause == CAUSE_PIN_RUN && !sleepEnter |=> statusByte_ff[7:5] == 3'h0
      && statusByte_ff[4:0] == $past(statusByte_ff[4:0])
      && powerControlReg_ff == $past(powerControlReg_ff))
    else $error("running pin reset altered kept bits");

  a_pin_sleep_flags: assert property (
    clkEn && nxt_cause == CAUSE_PIN_SLEEP |=> statusByte_ff[7:3] == 5'h02
      && pcTarget_ff == '0 && !asleep_ff)
    else $error("sleeping pin reset flags wrong");

  a_watchdog_run_flags: assert property (
    clkEn && nxt_cause == CAUSE_WATCHDOG_RUN |=> statusByte_ff[7:4] == 4'h0
      && statusByte_ff[3] == $past(statusByte_ff[3]) && coreReset_ff)
    else $error("running watchdog reset flags wrong");

  a_watchdog_wake_pc: assert property (
    clkEn && nxt_cause == CAUSE_WATCHDOG_WAKE |=> pcLoad_ff
      && pcTarget_ff == $past(pcIn) + 1'b1 && statusByte_ff[4:3] == 2'h0 && !coreReset_ff)
    else $error("watchdog wake-up wrong");

  a_irq_wake_flags: assert property (
    clkEn && nxt_cause == CAUSE_IRQ_WAKE |=> statusByte_ff[4:3] == 2'h2
      && statusByte_ff[7:5] == $past(statusByte_ff[7:5]))
    else $error("interrupt wake-up flags wrong");

  a_vector_pend_set: assert property (
    clkEn && nxt_cause == CAUSE_IRQ_WAKE |=> vectorPend_ff == $past(globalIrqEnable))
    else $error("vector pending does not follow the global enable");

  a_vector_after_wake: assert property (
    clkEn && vectorPend_ff && instrDone && nxt_cause == CAUSE_NONE
      |=> pcLoad_ff && pcTarget_ff == PC_W'(`IRQ_VECTOR))
    else $error("vector branch missing after wake");

  a_pwrflag_sw_set: assert property (
    clkEn && nxt_cause != CAUSE_BROWNOUT |=> (powerControlReg_ff & $past(powerControlReg_ff))
      == $past(powerControlReg_ff))
    else $error("power flag cleared without brown-out");

  a_irq_set_wins: assert property (
    clkEn && |irqSet |=> (irqStat_ff & $past(irqSet)) == $past(irqSet))
    else $error("event lost against clear");

endmodule : reset_cause_and_wakeup_state

/* verif/tb.sv */
`timescale 1ns/1ns
module tb;
  import reset_cause_pkg::*;

  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  localparam int MC = 4;
  logic clk, reset_n, clkEn, masterClearPin_n, brownoutEvent, watchdogExpire;
  logic irqPending, globalIrqEnable, sleepEnter, instrDone;
  logic [12:0] pcIn;
  logic [12:0] pcTarget;
  regReq_t regReq;
  logic [7:0] regRdData;
  logic [7:0] rdv;
  logic pcLoad, coreReset, asleep, irq;
  int num_errors = 0;
  int tests_run = 0;
  int loadCount = 0;
  int lc0;

  reset_cause_and_wakeup_state #(.PC_W(13), .HOLD_N(4), .PIN_FILT_CYC(MC))
    reset_cause_and_wakeup_state_i (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .masterClearPin_n(masterClearPin_n),
    .brownoutEvent(brownoutEvent), .watchdogExpire(watchdogExpire), .irqPending(irqPending),
    .globalIrqEnable(globalIrqEnable), .sleepEnter(sleepEnter), .instrDone(instrDone),
    .pcIn(pcIn), .regReq(regReq), .regRdData(regRdData), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .coreReset(coreReset), .asleep(asleep), .irq(irq)
  );

  // clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts pc load pulses so ignored events can be seen
  always @(posedge clk) begin
    if (pcLoad === 1'b1) loadCount <= loadCount + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task complete_run;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    // read data stand until the next edge and are taken there
    @(posedge clk);
    rdv = regRdData;
    check({8'h00, rdv}, {8'h00, exp});
  endtask : rchk

  // single-cycle event pulse: 0 watchdog, 1 sleep, 2 brown-out, 3 instruction done
  task pulse(input int which);
    @(posedge clk);
    case (which)
      0: watchdogExpire <= 1'b1;
      1: sleepEnter <= 1'b1;
      2: brownoutEvent <= 1'b1;
      default: instrDone <= 1'b1;
    endcase
    @(posedge clk);
    watchdogExpire <= 1'b0;
    sleepEnter <= 1'b0;
    brownoutEvent <= 1'b0;
    instrDone <= 1'b0;
  endtask : pulse

  // bounded wait for a pc load, then compare target and core reset
  task wait_load(input logic [12:0] tgt, input logic rst);
    int i;
    for (i = 0; i < 40; i++) begin
      // a read at the edge sees the pulse of the cycle just ended
      @(posedge clk);
      if (pcLoad === 1'b1) break;
    end
    if (i == 40) begin
      num_errors++;
      $display("Error at %0t: no pc load seen", $time);
      complete_run();
    end
    check({3'b000, pcTarget}, {3'b000, tgt});
    check({15'h0000, coreReset}, {15'h0000, rst});
  endtask : wait_load

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    masterClearPin_n = 1'b1;
    brownoutEvent = 1'b0;
    watchdogExpire = 1'b0;
    irqPending = 1'b0;
    globalIrqEnable = 1'b1;
    sleepEnter = 1'b0;
    instrDone = 1'b0;
    pcIn = 13'h0000;
    regReq = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // power-on values and write masking
    rchk(8'h03, 8'h18);
    rchk(8'h0E, 8'h00);
    rchk(8'h10, 8'h01);
    rchk(8'h11, 8'h00);
    wr(8'h10, 8'h3F);
    rchk(8'h10, 8'h00);
    wr(8'h03, 8'hE5);
    rchk(8'h03, 8'hFD);
    wr(8'h0E, 8'h03);
    rchk(8'h0E, 8'h03);
    wr(8'h20, 8'h5A);
    wr(8'h7F, 8'hFF);
    rchk(8'h7F, 8'h00);
    // short pin glitch is filtered out
    lc0 = loadCount;
    @(posedge clk);
    masterClearPin_n <= 1'b0;
    repeat (MC - 1) @(posedge clk);
    masterClearPin_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(16'(loadCount - lc0), 16'h0000);
    // pin reset while running
    @(posedge clk);
    masterClearPin_n <= 1'b0;
    wait_load(13'h0000, 1'b1);
    @(posedge clk);
    masterClearPin_n <= 1'b1;
    rchk(8'h03, 8'h1D);
    rchk(8'h0E, 8'h03);
    rchk(8'h20, 8'h5A);
    // watchdog reset while running
    wr(8'h03, 8'hFF);
    pulse(0);
    wait_load(13'h0000, 1'b1);
    rchk(8'h03, 8'h0F);
    // pending interrupt while awake is ignored
    lc0 = loadCount;
    @(posedge clk);
    irqPending <= 1'b1;
    repeat (5) @(posedge clk);
    irqPending <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'(loadCount - lc0), 16'h0000);
    // watchdog wake from sleep
    pulse(1);
    repeat (2) @(posedge clk);
    check({15'h0000, asleep}, 16'h0001);
    rchk(8'h03, 8'h17);
    wr(8'h03, 8'hE7);
    rchk(8'h03, 8'hF7);
    pcIn <= 13'h0123;
    pulse(0);
    wait_load(13'h0124, 1'b0);
    rchk(8'h03, 8'hE7);
    check({15'h0000, asleep}, 16'h0000);
    // interrupt wake with global enable, then vector
    pulse(1);
    pcIn <= 13'h0200;
    @(posedge clk);
    irqPending <= 1'b1;
    wait_load(13'h0201, 1'b0);
    @(posedge clk);
    irqPending <= 1'b0;
    rchk(8'h03, 8'hF7);
    pulse(3);
    wait_load(13'h0004, 1'b0);
    // interrupt wake with the global enable clear: no vector follows
    globalIrqEnable <= 1'b0;
    pulse(1);
    @(posedge clk);
    irqPending <= 1'b1;
    wait_load(13'h0201, 1'b0);
    @(posedge clk);
    irqPending <= 1'b0;
    lc0 = loadCount;
    pulse(3);
    repeat (3) @(posedge clk);
    check(16'(loadCount - lc0), 16'h0000);
    globalIrqEnable <= 1'b1;
    // pin reset while asleep
    pulse(1);
    repeat (2) @(posedge clk);
    masterClearPin_n <= 1'b0;
    wait_load(13'h0000, 1'b1);
    @(posedge clk);
    masterClearPin_n <= 1'b1;
    rchk(8'h03, 8'h17);
    // a watchdog pulse while the clock enable is low is not seen
    lc0 = loadCount;
    @(posedge clk);
    clkEn <= 1'b0;
    pulse(0);
    @(posedge clk);
    clkEn <= 1'b1;
    repeat (3) @(posedge clk);
    check(16'(loadCount - lc0), 16'h0000);
    rchk(8'h03, 8'h17);
    // brown-out
    pulse(2);
    wait_load(13'h0000, 1'b1);
    rchk(8'h03, 8'h18);
    rchk(8'h0E, 8'h02);
    rchk(8'h20, 8'h5A);
    // each cause left its own event bit; mask and clear the interrupt
    rchk(8'h10, 8'h3E);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h11, 8'h02);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0001);
    wr(8'h10, 8'h02);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0000);
    rchk(8'h10, 8'h3C);
    complete_run();
  end

endmodule : tb
